// ==== bench/gdl_bus_partner.sv ====
// far-side instrument model: open-drain lines and dio with pull-ups
`timescale 1ns/1ns
`default_nettype none
module gdl_bus_partner (
  // device pin drive
  input  wire gdl_pkg::gdl_lines_t line_oe_in,
  input  wire logic [7:0]          dio_in,
  input  wire logic                dio_oe_in,
  // instrument side requests
  input  wire gdl_pkg::gdl_lines_t ext_assert_in,
  input  wire logic [7:0]          ext_byte_in,
  input  wire logic                ext_talk_in,
  // resulting pin levels, low = asserted
  output gdl_pkg::gdl_lines_t      line_n_out,
  output logic [7:0]               dio_n_out
);
  // wired-and: any party pulling low wins, else pull-up high
  assign line_n_out = ~(line_oe_in | ext_assert_in);
  // dio: device byte, instrument byte, or released to the pull-ups
  assign dio_n_out = dio_oe_in ? dio_in : (ext_talk_in ? ~ext_byte_in : 8'hff);
endmodule
`default_nettype wire

// ==== bench/gpib_data_and_line_registers_test.sv ====
// self-checking bench of the gpib data and line registers
`timescale 1ns/1ns
`default_nettype none
module gpib_data_and_line_registers_test;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0;
  logic lacs = 1'b0, acds = 1'b0, tacs = 1'b0, sgns = 1'b0, shs = 1'b0;
  logic xtalk = 1'b0, dack = 1'b0, dreq, nba, hold, endf, dio_oe;
  logic out_flag, in_flag;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, xbyte = 8'h00, rdata, dio_out, dio_n, d;
  gdl_pkg::gdl_lines_t drive = 8'h00, txen = 8'h00, ext = 8'h00;
  gdl_pkg::gdl_lines_t view, pin_oe, pin_n;
  int failures = 0, cmp_count = 0;
  // clock, 10 ns period
  always #5 clk_sys_in = ~clk_sys_in;
  gdl_top DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .host_addr_in(addr), .host_rd_in(rd), .host_wr_in(wr),
    .host_wdata_in(wdata), .dma_ack_in(dack), .host_rdata_out(rdata),
    .dma_request_out(dreq), .lacs_in(lacs), .acds_in(acds), .tacs_in(tacs),
    .cacs_in(1'b0), .sgns_in(sgns), .sh_sent_in(shs), .line_drive_in(drive),
    .line_tx_en_in(txen), .line_view_out(view), .nba_out(nba),
    .rfd_holdoff_out(hold), .byte_out_flag_out(out_flag),
    .byte_in_flag_out(in_flag),
    .end_flag_out(endf), .line_pin_in(pin_n), .line_pin_out(),
    .line_pin_oe_out(pin_oe), .dio_pin_in(dio_n), .dio_pin_out(dio_out),
    .dio_pin_oe_out(dio_oe));
  gdl_bus_partner far (.line_oe_in(pin_oe), .dio_in(dio_out),
    .dio_oe_in(dio_oe), .ext_assert_in(ext), .ext_byte_in(xbyte),
    .ext_talk_in(xtalk), .line_n_out(pin_n), .dio_n_out(dio_n));
  // compare and count
  task automatic chk(input string nm, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one host write, strobe held one cycle
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  // one host read, answer taken after it has landed
  task automatic rreg(input logic [2:0] a);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
    #1 d = rdata;
  endtask
  // let the pin synchronisers and flags settle
  task automatic settle();
    repeat (5) @(posedge clk_sys_in);
    #1;
  endtask
  // force, view, sample and paging
  task automatic test_lines();
    @(posedge clk_sys_in);
    ext <= 8'h01;
    drive <= 8'h04;
    wreg(3'h5, 8'h1f);
    wreg(3'h2, 8'h80);
    settle();
    chk("view", view, 8'h85);
    chk("oe_rx", pin_oe, 8'h00);
    rreg(3'h3);
    chk("sample_rx", d, 8'h01);
    @(posedge clk_sys_in);
    txen <= 8'h80;
    settle();
    chk("oe_tx", pin_oe, 8'h80);
    rreg(3'h3);
    chk("sample_tx", d, 8'h81);
    wreg(3'h5, 8'h9c);
    wreg(3'h2, 8'h00);
    settle();
    chk("unpaged", view, 8'h85);
    wreg(3'h5, 8'h1f);
    wreg(3'h2, 8'h00);
    @(posedge clk_sys_in);
    txen <= 8'h00;
    ext <= 8'h00;
    drive <= 8'h00;
    settle();
    chk("cleared", view, 8'h00);
    wreg(3'h5, 8'h1f);
    wreg(3'h5, 8'h1e);
    wreg(3'h2, 8'h80);
    wreg(3'h5, 8'h1f);
    wreg(3'h5, 8'h02);
    wreg(3'h2, 8'h80);
    settle();
    chk("repaged", view, 8'h00);
  endtask
  // capture as listener with seven-bit end match and dma
  task automatic test_listen();
    wreg(3'h5, 8'h9f);
    wreg(3'h2, 8'h01);
    wreg(3'h5, 8'h9e);
    wreg(3'h2, 8'h8a);
    wreg(3'h1, 8'h44);
    @(posedge clk_sys_in);
    xtalk <= 1'b1;
    xbyte <= 8'h0a;
    settle();
    @(posedge clk_sys_in);
    lacs <= 1'b1;
    acds <= 1'b1;
    settle();
    chk("rx_flags", {4'h0, in_flag, hold, endf, dreq}, 8'h0f);
    rreg(3'h4);
    chk("pass", d, 8'h0a);
    @(posedge clk_sys_in);
    lacs <= 1'b0;
    acds <= 1'b0;
    xtalk <= 1'b0;
    dack <= 1'b1;
    rreg(3'h0);
    dack <= 1'b0;
    chk("dir", d, 8'h0a);
    chk("rd_flags", {4'h0, in_flag, hold, endf, dreq}, 8'h02);
  endtask
  // talker writes, transparent dio and end marking
  task automatic test_talk();
    wreg(3'h1, 8'h88);
    @(posedge clk_sys_in);
    txen <= 8'h08;
    tacs <= 1'b1;
    wreg(3'h7, 8'h55);
    #1 chk("dio", dio_out, 8'haa);
    chk("dio_oe", {7'h0, dio_oe}, 8'h01);
    settle();
    chk("nba_bo", {5'h0, nba, out_flag, pin_oe.eoi}, 8'h04);
    rreg(3'h7);
    chk("dir_kept", d, 8'h0a);
    wreg(3'h7, 8'h0a);
    settle();
    chk("eoi_dio", dio_out, 8'hf5);
    chk("eoi", {7'h0, pin_oe.eoi}, 8'h01);
    @(posedge clk_sys_in);
    shs <= 1'b1;
    sgns <= 1'b1;
    @(posedge clk_sys_in);
    shs <= 1'b0;
    settle();
    chk("sent", {5'h0, nba, out_flag, dreq}, 8'h03);
    @(posedge clk_sys_in);
    sgns <= 1'b0;
    dack <= 1'b1;
    wreg(3'h0, 8'h33);
    dack <= 1'b0;
    settle();
    chk("dma_wr", {5'h0, nba, out_flag, dreq}, 8'h04);
    chk("dma_dio", dio_out, 8'hcc);
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence after 3 cycles of reset
  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    test_lines();
    test_listen();
    test_talk();
    report_and_stop();
  end
  // watchdog well beyond the roughly 130 cycles needed
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== rtl/gdl_consts.svh ====
// constants of the gpib data and line register block
`ifndef GDL_CONSTS_SVH
`define GDL_CONSTS_SVH

// ****************************************
// register offsets on the host port
// ****************************************
`define GDL_OFS_STATUS   3'h0
`define GDL_OFS_CONFIG   3'h1
`define GDL_OFS_PAGED    3'h2
`define GDL_OFS_SAMPLE   3'h3
`define GDL_OFS_PASS     3'h4
`define GDL_OFS_AUX      3'h5
`define GDL_OFS_DATA     3'h7

// ****************************************
// auxiliary command codes
// ****************************************
`define GDL_CMD_PI_ACC   8'h9f
`define GDL_CMD_PI_FORCE 8'h1f
`define GDL_CMD_PI_MATCH 8'h9e
`define GDL_CMD_CLR_PI   8'h9c
`define GDL_CMD_PI_IMR2  8'h1e
`define GDL_CMD_CHIP_RST 8'h02

// ****************************************
// field positions
// ****************************************
`define GDL_CFG_DMA_OUT  7
`define GDL_CFG_DMA_IN   6
`define GDL_CFG_BINARY   4
`define GDL_CFG_TX_END   3
`define GDL_CFG_RX_END   2
`define GDL_ACC_DMA_EN   0
`define GDL_LN_NDAC      5
`define GDL_LN_NRFD      4
`define GDL_LN_EOI       3
`define GDL_LN_SRQ       2
`define GDL_OWN_SEEN     8'h34
`define GDL_SEVEN_MASK   8'h7f
`define GDL_EIGHT_MASK   8'hff

// ****************************************
// reset values
// ****************************************
`define GDL_RST_BYTE     8'h00

`endif

// ==== rtl/gdl_eos_cmp.sv ====
// end-of-string byte comparator, seven or eight bits
`timescale 1ns/1ns
`default_nettype none
`include "gdl_consts.svh"
module gdl_eos_cmp (
  // compared bytes
  input  wire logic [7:0] byte_in,
  input  wire logic [7:0] match_in,
  // mode
  input  wire logic       binary_compare_select_in,
  // result
  output logic            hit_out
);
  logic [7:0] mask;  // bits taking part

  // bit 7 drops out of both sides in seven-bit mode
  always_comb begin
    mask    = binary_compare_select_in ? `GDL_EIGHT_MASK
                                       : `GDL_SEVEN_MASK;
    hit_out = ((byte_in ^ match_in) & mask) == 8'h00;
  end
endmodule
`default_nettype wire

// ==== rtl/gdl_pkg.sv ====
// types of the gpib data and line register block
package gdl_pkg;

  // ****************************************
  // the eight management and handshake lines
  // ****************************************
  typedef struct packed {
    logic atn;
    logic dav;
    logic ndac;
    logic nrfd;
    logic eoi;
    logic srq;
    logic ifc;
    logic ren;
  } gdl_lines_t;

  // ****************************************
  // what sits at the shared paged slot
  // ****************************************
  typedef enum logic [1:0] {
    GDL_PAGE_NONE  = 2'b00,
    GDL_PAGE_ACC   = 2'b01,
    GDL_PAGE_FORCE = 2'b10,
    GDL_PAGE_MATCH = 2'b11
  } gdl_page_t;

endpackage

// ==== rtl/gdl_top.sv ====
// gpib data latches, line force/sample and end-of-string match
`timescale 1ns/1ns
`default_nettype none
`include "gdl_consts.svh"
module gdl_top (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  // host register port, same clock
  input  wire logic [2:0]        host_addr_in,
  input  wire logic              host_rd_in,
  input  wire logic              host_wr_in,
  input  wire logic [7:0]        host_wdata_in,
  input  wire logic              dma_ack_in,
  output logic [7:0]             host_rdata_out,
  output logic                   dma_request_out,
  // interface function side, same clock
  input  wire logic              lacs_in,
  input  wire logic              acds_in,
  input  wire logic              tacs_in,
  input  wire logic              cacs_in,
  input  wire logic              sgns_in,
  input  wire logic              sh_sent_in,
  input  wire gdl_pkg::gdl_lines_t line_drive_in,
  input  wire gdl_pkg::gdl_lines_t line_tx_en_in,
  output gdl_pkg::gdl_lines_t    line_view_out,
  output logic                   nba_out,
  output logic                   rfd_holdoff_out,
  output logic                   byte_out_flag_out,
  output logic                   byte_in_flag_out,
  output logic                   end_flag_out,
  // gpib pins, low level means asserted
  input  wire gdl_pkg::gdl_lines_t line_pin_in,
  output gdl_pkg::gdl_lines_t    line_pin_out,
  output gdl_pkg::gdl_lines_t    line_pin_oe_out,
  input  wire logic [7:0]        dio_pin_in,
  output logic [7:0]             dio_pin_out,
  output logic                   dio_pin_oe_out
);

  // ****************************************
  // state
  // ****************************************
  gdl_pkg::gdl_page_t page_reg;       // occupant of paged slot
  logic [7:0] accessory_reg;          // accessory byte, bit 0 dma master
  logic [7:0] bus_line_force_reg;     // forced line bits
  logic [7:0] end_string_match_reg;   // stored match byte
  logic [7:0] config_reg;             // dma and end-of-string enables
  logic [7:0] data_out_latch_reg;     // pending output byte
  logic [7:0] data_in_latch_reg;      // last received byte
  logic       nba_reg;                // new byte available
  logic       byte_out_flag_reg;      // latch empty while talking
  logic       byte_in_flag_reg;       // byte waiting to be read
  logic       data_in_flag_reg;       // byte captured since last read
  logic       end_flag_reg;           // end-of-string seen
  logic       holdoff_reg;            // ready-for-data holdoff
  logic       dma_request_reg;        // dma request
  logic       capture_d_reg;          // capture condition last cycle
  logic [7:0] rdata_reg;              // read answer
  logic [7:0] line_meta_reg;          // line synchroniser, first stage
  logic [7:0] line_sync_reg;          // line synchroniser, second stage
  logic [7:0] dio_meta_reg;           // dio synchroniser, first stage
  logic [7:0] dio_sync_reg;           // dio synchroniser, second stage
  logic [7:0] view_reg;               // line values seen inside
  logic [7:0] pin_oe_reg;             // line pin enables
  logic [7:0] dio_out_reg;            // dio pin levels
  logic       dio_oe_reg;             // dio pin enable

  // ****************************************
  // decode
  // ****************************************
  logic       wr_aux;                 // auxiliary command write
  logic       wr_paged;               // write to shared slot
  logic       wr_data;                // host or dma write of output byte
  logic       rd_data;                // host or dma read of input byte
  logic       rd_status;              // status read
  logic       chip_rst;               // chip reset command
  logic       capture;                // listener accepting
  logic       capture_rise;           // first cycle of a capture
  logic       byte_out_set;           // byte out set term
  logic       dma_master_enable;      // dma master enable
  logic [7:0] rx_lines;               // asserted levels from pins
  logic [7:0] tx_en;                  // transmit enables
  logic [7:0] drive_val;              // value offered to each line
  logic [7:0] sample_val;             // transceiver-side sample
  logic       rx_hit;                 // received byte matches
  logic       tx_hit;                 // output byte matches

  // host strobes; a dma cycle ignores the address
  always_comb begin
    wr_aux    = host_wr_in && !dma_ack_in &&
                host_addr_in == `GDL_OFS_AUX;
    wr_paged  = host_wr_in && !dma_ack_in &&
                host_addr_in == `GDL_OFS_PAGED;
    wr_data   = host_wr_in &&
                (dma_ack_in || host_addr_in == `GDL_OFS_DATA);
    rd_data   = host_rd_in &&
                (dma_ack_in || host_addr_in == `GDL_OFS_DATA);
    rd_status = host_rd_in && !dma_ack_in &&
                host_addr_in == `GDL_OFS_STATUS;
    chip_rst  = wr_aux && host_wdata_in == `GDL_CMD_CHIP_RST;
  end

  // listener capture and talker empty-latch terms
  always_comb begin
    capture           = lacs_in && acds_in;
    capture_rise      = capture && !capture_d_reg;
    byte_out_set      = (cacs_in || tacs_in) && sgns_in && !nba_reg;
    dma_master_enable = accessory_reg[`GDL_ACC_DMA_EN];
  end

  // line values: force reaches the sample and the pin enable only where the line transmits
  always_comb begin
    rx_lines   = ~line_sync_reg;
    tx_en      = line_tx_en_in;
    drive_val  = line_drive_in | bus_line_force_reg;
    drive_val[`GDL_LN_EOI] = drive_val[`GDL_LN_EOI] ||
      (tacs_in && config_reg[`GDL_CFG_TX_END] && nba_reg &&
       tx_hit);
    sample_val = (tx_en & drive_val) | (~tx_en & rx_lines);
  end

  // ****************************************
  // end-of-string comparators
  // ****************************************
  gdl_eos_cmp u_rx_cmp (
    .byte_in                  (dio_sync_reg ^ `GDL_EIGHT_MASK),
    .match_in                 (end_string_match_reg),
    .binary_compare_select_in (config_reg[`GDL_CFG_BINARY]),
    .hit_out                  (rx_hit)
  );
  gdl_eos_cmp u_tx_cmp (
    .byte_in                  (data_out_latch_reg),
    .match_in                 (end_string_match_reg),
    .binary_compare_select_in (config_reg[`GDL_CFG_BINARY]),
    .hit_out                  (tx_hit)
  );

  // ****************************************
  // synchronisers
  // ****************************************

  // pins cross into the clock domain over two stages
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      line_meta_reg <= `GDL_EIGHT_MASK;
      line_sync_reg <= `GDL_EIGHT_MASK;
      dio_meta_reg  <= `GDL_EIGHT_MASK;
      dio_sync_reg  <= `GDL_EIGHT_MASK;
    end else begin
      line_meta_reg <= line_pin_in;
      line_sync_reg <= line_meta_reg;
      dio_meta_reg  <= dio_pin_in;
      dio_sync_reg  <= dio_meta_reg;
    end
  end

  // ****************************************
  // paging and configuration
  // ****************************************

  // paged slot occupant, held until a new command
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      page_reg <= gdl_pkg::GDL_PAGE_NONE;
    end else if (wr_aux) begin
      case (host_wdata_in)
        `GDL_CMD_PI_ACC:   page_reg <= gdl_pkg::GDL_PAGE_ACC;
        `GDL_CMD_PI_FORCE: page_reg <= gdl_pkg::GDL_PAGE_FORCE;
        `GDL_CMD_PI_MATCH: page_reg <= gdl_pkg::GDL_PAGE_MATCH;
        `GDL_CMD_PI_IMR2:  page_reg <= gdl_pkg::GDL_PAGE_NONE;
        `GDL_CMD_CLR_PI:   page_reg <= gdl_pkg::GDL_PAGE_NONE;
        `GDL_CMD_CHIP_RST: page_reg <= gdl_pkg::GDL_PAGE_NONE;
        default:           page_reg <= page_reg;
      endcase
    end
  end

  // paged registers; with nothing paged a write is dropped
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      accessory_reg        <= `GDL_RST_BYTE;
      bus_line_force_reg   <= `GDL_RST_BYTE;
      end_string_match_reg <= `GDL_RST_BYTE;
    end else if (wr_paged) begin
      case (page_reg)
        gdl_pkg::GDL_PAGE_ACC:   accessory_reg <= host_wdata_in;
        gdl_pkg::GDL_PAGE_FORCE: bus_line_force_reg <= host_wdata_in;
        gdl_pkg::GDL_PAGE_MATCH: end_string_match_reg <= host_wdata_in;
        default:                accessory_reg <= accessory_reg;
      endcase
    end
  end

  // enable bits for dma and end-of-string
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      config_reg <= `GDL_RST_BYTE;
    end else if (host_wr_in && !dma_ack_in &&
                 host_addr_in == `GDL_OFS_CONFIG) begin
      config_reg <= host_wdata_in;
    end
  end

  // ****************************************
  // data latches, kept apart
  // ****************************************

  // output byte, touched only by output writes
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      data_out_latch_reg <= `GDL_RST_BYTE;
    end else if (wr_data) begin
      data_out_latch_reg <= host_wdata_in;
    end
  end

  // input byte follows the dio lines while capturing
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      data_in_latch_reg <= `GDL_RST_BYTE;
      capture_d_reg     <= 1'b0;
    end else begin
      capture_d_reg <= capture;
      if (capture) begin
        data_in_latch_reg <= ~dio_sync_reg;
      end
    end
  end

  // ****************************************
  // handshake messages and flags
  // ****************************************

  // new byte available: set by output write, cleared when sent
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      nba_reg <= 1'b0;
    end else if (wr_data) begin
      nba_reg <= 1'b1;
    end else if (sh_sent_in || chip_rst) begin
      nba_reg <= 1'b0;
    end
  end

  // byte out flag; a set beats a clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      byte_out_flag_reg <= 1'b0;
    end else if (byte_out_set) begin
      byte_out_flag_reg <= 1'b1;
    end else if (wr_data || chip_rst) begin
      byte_out_flag_reg <= 1'b0;
    end
  end

  // byte in, data in and end flags; a set beats a clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      byte_in_flag_reg <= 1'b0;
      data_in_flag_reg <= 1'b0;
      end_flag_reg     <= 1'b0;
    end else begin
      if (capture_rise) begin
        byte_in_flag_reg <= 1'b1;
        data_in_flag_reg <= 1'b1;
      end else if (rd_data || rd_status || chip_rst) begin
        byte_in_flag_reg <= 1'b0;
        data_in_flag_reg <= rd_data ? 1'b0 : data_in_flag_reg;
      end
      if (capture_rise && config_reg[`GDL_CFG_RX_END] && rx_hit) begin
        end_flag_reg <= 1'b1;
      end else if (rd_status || chip_rst) begin
        end_flag_reg <= 1'b0;
      end
    end
  end

  // ready-for-data holdoff from capture until the byte is read
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      holdoff_reg <= 1'b0;
    end else if (capture_rise) begin
      holdoff_reg <= 1'b1;
    end else if (rd_data || chip_rst) begin
      holdoff_reg <= 1'b0;
    end
  end

  // dma request, dropped by a data cycle unless that path is off
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      dma_request_reg <= 1'b0;
    end else if (dma_master_enable &&
                 ((config_reg[`GDL_CFG_DMA_OUT] && tacs_in &&
                   byte_out_set) ||
                  (config_reg[`GDL_CFG_DMA_IN] && capture_rise))) begin
      dma_request_reg <= 1'b1;
    end else if (wr_data &&
                 !(dma_master_enable && !config_reg[`GDL_CFG_DMA_OUT])) begin
      dma_request_reg <= 1'b0;
    end else if (rd_data &&
                 !(dma_master_enable && !config_reg[`GDL_CFG_DMA_IN])) begin
      dma_request_reg <= 1'b0;
    end else if (chip_rst) begin
      dma_request_reg <= 1'b0;
    end
  end

  // ****************************************
  // host read answer
  // ****************************************

  // answer sampled in the read cycle, shown the next
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg <= `GDL_RST_BYTE;
    end else if (host_rd_in) begin
      if (rd_data) begin
        rdata_reg <= data_in_latch_reg;
      end else begin
        case (host_addr_in)
          `GDL_OFS_STATUS: rdata_reg <= {2'b00, byte_in_flag_reg,
                                         byte_out_flag_reg, end_flag_reg,
                                         data_in_flag_reg, nba_reg,
                                         holdoff_reg};
          `GDL_OFS_SAMPLE: rdata_reg <= sample_val;
          `GDL_OFS_PASS:   rdata_reg <= ~dio_sync_reg;
          `GDL_OFS_PAGED:  rdata_reg <= (page_reg == gdl_pkg::GDL_PAGE_FORCE)
                                        ? sample_val : `GDL_RST_BYTE;
          default:         rdata_reg <= `GDL_RST_BYTE;
        endcase
      end
    end
  end

  // ****************************************
  // pin and view outputs
  // ****************************************

  // lines: enable only where transmitting; view is rx, force or own ndac/nrfd/srq drive
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pin_oe_reg <= `GDL_RST_BYTE;
      view_reg   <= `GDL_RST_BYTE;
    end else begin
      pin_oe_reg <= tx_en & drive_val;
      view_reg   <= rx_lines | bus_line_force_reg |
                    (line_drive_in & `GDL_OWN_SEEN);
    end
  end

  // dio levels follow host data in a write cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      dio_out_reg <= `GDL_EIGHT_MASK;
      dio_oe_reg  <= 1'b0;
    end else begin
      dio_out_reg <= ~(wr_data ? host_wdata_in
                               : data_out_latch_reg);
      dio_oe_reg  <= tacs_in || cacs_in;
    end
  end

  assign host_rdata_out    = rdata_reg;
  assign dma_request_out   = dma_request_reg;
  assign line_view_out     = view_reg;
  assign nba_out           = nba_reg;
  assign rfd_holdoff_out   = holdoff_reg;
  assign byte_out_flag_out = byte_out_flag_reg;
  assign byte_in_flag_out  = byte_in_flag_reg;
  assign end_flag_out      = end_flag_reg;
  assign line_pin_out      = `GDL_RST_BYTE;
  assign line_pin_oe_out   = pin_oe_reg;
  assign dio_pin_out       = dio_out_reg;
  assign dio_pin_oe_out    = dio_oe_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  AST_PAGE_ACCESSORY: assert property (
    wr_aux && host_wdata_in == `GDL_CMD_PI_ACC
    |=> page_reg == gdl_pkg::GDL_PAGE_ACC)
    else $error("accessory page-in not taken");
  AST_PAGE_HOLD: assert property (
    !wr_aux |=> page_reg == $past(page_reg))
    else $error("paging changed without command");
  AST_CLR_IGNORE: assert property (
    page_reg == gdl_pkg::GDL_PAGE_NONE && wr_paged
    |=> $stable(accessory_reg) && $stable(bus_line_force_reg) &&
        $stable(end_string_match_reg))
    else $error("write to unmapped slot took effect");
  AST_PIN_GATED: assert property (
    ##1 line_pin_oe_out == ($past(tx_en) & $past(drive_val)))
    else $error("line pin enable wrong");
  AST_VIEW_OR: assert property (
    ##1 (line_view_out & $past(bus_line_force_reg)) ==
        $past(bus_line_force_reg))
    else $error("force bit missing from internal view");
  AST_NBA_SET: assert property (
    wr_data |=> nba_out ##1 (nba_out || $past(sh_sent_in)))
    else $error("new byte available not set");
  AST_BYTE_OUT_CLR: assert property (
    wr_data && !byte_out_set |=> !byte_out_flag_out)
    else $error("byte out flag not cleared");
  AST_BYTE_IN_SET: assert property (
    capture_rise |=> byte_in_flag_out && rfd_holdoff_out)
    else $error("capture did not set flag and holdoff");
  AST_BYTE_IN_CLR: assert property (
    rd_data && !capture_rise |=> !byte_in_flag_out && !rfd_holdoff_out)
    else $error("data read did not clear flag");
  AST_EOI_TX: assert property (
    tacs_in && config_reg[`GDL_CFG_TX_END] && nba_reg && tx_hit &&
    tx_en[`GDL_LN_EOI] |=> line_pin_oe_out[`GDL_LN_EOI])
    else $error("EOI not sent with matching byte");

  COV_CAPTURE_READ: cover property (
    capture_rise ##[1:20] rd_data);
  COV_WRITE_SENT: cover property (
    wr_data ##[1:20] sh_sent_in);
  COV_END_SEEN: cover property (
    capture_rise && config_reg[`GDL_CFG_RX_END] && rx_hit);
endmodule
`default_nettype wire
